// *** design/stimulus_port_enable_trigger.sv ***
`timescale 1ns/1ps
`include "stim_gate_regs.svh"

module stimulus_port_enable_trigger
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register bus
    input stim_gate_pkg::apb_req_t apbReq,
    output stim_gate_pkg::apb_rsp_t apbRsp,
    // Trace side
    input wire logic traceReady,
    output stim_gate_pkg::trace_write_t traceOut
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    stim_gate_pkg::state_t s_q;
    stim_gate_pkg::state_t s_d;

    logic setupPhase;
    logic accessPhase;
    logic inStim;
    logic [4:0] portIdx;
    logic portOn;
    logic trigOn;
    logic writeOk;
    logic [31:0] rdNext;
    logic [11:0] wordAddr;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    always_comb
    begin
        setupPhase = apbReq.psel && !apbReq.penable;
        accessPhase = apbReq.psel && apbReq.penable;
        wordAddr = {apbReq.paddr[11:2], 2'h0};
        // Lock state never gates this window
        inStim = `HAS_BASIC && (wordAddr <= `STIM_LAST_OFS);
        portIdx = wordAddr[6:2];
    end

    // ------------------------------------------------------------
    // Port gating
    // ------------------------------------------------------------
    // Basic ports all sit in group zero of the extended space
    always_comb
    begin
        // Mode zero and one leave the enable mask on every group
        portOn = s_q.portEn[portIdx];
        if (s_q.selMode == `MODE_BOTH)
        begin
            portOn = portOn && (s_q.groupSel == `GROUP_RST);
        end
        trigOn = s_q.trigEn[portIdx] && portOn;
        if (s_q.selMode != `MODE_NONE)
        begin
            trigOn = trigOn && (s_q.groupSel == `GROUP_RST);
        end
        // Readiness needs the port on and room downstream
        writeOk = portOn && traceReady;
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb
    begin
        rdNext = 32'h0000_0000;
        if (inStim)
        begin
            rdNext[`READY_BIT] = writeOk;
        end
        else
        begin
            unique case (wordAddr)
                `PORT_EN_OFS:
                begin
                    rdNext = s_q.portEn;
                end
                `TRIG_EN_OFS:
                begin
                    // Absent mask reads as zero
                    rdNext = `HAS_TRIG ? s_q.trigEn : 32'h0000_0000;
                end
                `PORT_SEL_OFS:
                begin
                    if (`PORT_SEL_PRESENT)
                    begin
                        rdNext[`MODE_LSB +: `MODE_W] = s_q.selMode;
                        rdNext[`GROUP_LSB +: `GROUP_W] = s_q.groupSel;
                    end
                end
                `FEAT2_OFS:
                begin
                    rdNext[`FEAT2_BASIC_BIT] = `HAS_BASIC;
                    rdNext[`FEAT2_TRIG_BIT] = `HAS_TRIG;
                end
                default:
                begin
                    // Reserved space reads zero
                    rdNext = 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        // Forwarded write is a one-cycle pulse
        s_d.trace = '0;

        // Capture read data in setup so prdata comes from a flop
        if (setupPhase)
        begin
            s_d.rdata = rdNext;
        end

        if (accessPhase && apbReq.pwrite)
        begin
            if (inStim)
            begin
                // Refused writes vanish without trace
                if (writeOk)
                begin
                    s_d.trace.valid = 1'b1;
                    s_d.trace.master = `MASTER_ZERO;
                    s_d.trace.port = portIdx;
                    s_d.trace.data = apbReq.pwdata;
                    s_d.trace.marked = 1'b1;
                    s_d.trace.timestamped = 1'b1;
                    s_d.trace.trigger = trigOn;
                end
            end
            else
            begin
                unique case (wordAddr)
                    `PORT_EN_OFS:
                    begin
                        // Unimplemented bits stay zero
                        s_d.portEn = apbReq.pwdata & `MASK_IMPL;
                    end
                    `TRIG_EN_OFS:
                    begin
                        if (`HAS_TRIG)
                        begin
                            // Same width handling as enable
                            s_d.trigEn = apbReq.pwdata & `MASK_IMPL;
                        end
                    end
                    `PORT_SEL_OFS:
                    begin
                        if (`PORT_SEL_PRESENT)
                        begin
                            s_d.groupSel = apbReq.pwdata[`GROUP_LSB +: `GROUP_W];
                            // Reserved mode keeps old value, avoids undefined gating
                            if (apbReq.pwdata[`MODE_LSB +: `MODE_W] != `MODE_RSVD)
                            begin
                                s_d.selMode = apbReq.pwdata[`MODE_LSB +: `MODE_W];
                            end
                        end
                    end
                    default:
                    begin
                        // Read-only and reserved locations ignore writes
                        s_d.selMode = s_q.selMode;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            s_q.portEn <= `PORT_EN_RST;
            s_q.trigEn <= `TRIG_EN_RST;
            s_q.selMode <= `MODE_RST;
            s_q.groupSel <= `GROUP_RST;
            s_q.rdata <= 32'h0000_0000;
            s_q.trace <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Zero wait states: every access phase completes at once
    assign apbRsp.pready = 1'b1;
    assign apbRsp.pslverr = 1'b0;
    assign apbRsp.prdata = s_q.rdata;
    assign traceOut = s_q.trace;

endmodule

// *** pkg/stim_gate_pkg.sv ***
package stim_gate_pkg;

    // APB request from the master
    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    // One forwarded stimulus write
    typedef struct packed {
        logic valid;
        logic [15:0] master;
        logic [4:0] port;
        logic [31:0] data;
        logic marked;
        logic timestamped;
        logic trigger;
    } trace_write_t;

    // Whole state of the block
    typedef struct packed {
        logic [31:0] portEn;
        logic [31:0] trigEn;
        logic [1:0] selMode;
        logic [11:0] groupSel;
        logic [31:0] rdata;
        trace_write_t trace;
    } state_t;

endpackage

// *** pkg/stim_gate_regs.svh ***
`ifndef STIM_GATE_REGS_SVH
`define STIM_GATE_REGS_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define STIM_FIRST_OFS 12'h000
`define STIM_LAST_OFS 12'h07c
`define PORT_EN_OFS 12'he00
`define TRIG_EN_OFS 12'he20
`define PORT_SEL_OFS 12'he60
`define FEAT2_OFS 12'hea4

// ------------------------------------------------------------
// Configuration
// ------------------------------------------------------------
`define NUM_PORTS 64
`define BASIC_PORTS 32
`define HAS_BASIC 1'b1
`define HAS_TRIG 1'b1
`define PORT_SEL_PRESENT (`NUM_PORTS > `BASIC_PORTS)
`define MASK_IMPL 32'hffff_ffff

// ------------------------------------------------------------
// Field layouts
// ------------------------------------------------------------
`define READY_BIT 0
`define FEAT2_BASIC_BIT 0
`define FEAT2_TRIG_BIT 1
`define MODE_LSB 0
`define MODE_W 2
`define GROUP_LSB 20
`define GROUP_W 12
`define MODE_NONE 2'h0
`define MODE_TRIG 2'h1
`define MODE_RSVD 2'h2
`define MODE_BOTH 2'h3
`define MASTER_ZERO 16'h0000

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PORT_EN_RST 32'h0000_0000
`define TRIG_EN_RST 32'h0000_0000
`define MODE_RST 2'h0
`define GROUP_RST 12'h000

`endif

// *** tb/stim_gate_properties.sv ***
`timescale 1ns/1ps
module stim_gate_properties
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Watched ports
    input stim_gate_pkg::apb_req_t apbReq,
    input stim_gate_pkg::apb_rsp_t apbRsp,
    input wire logic traceReady,
    input stim_gate_pkg::trace_write_t traceOut
);
    wire logic stimAdr = apbReq.paddr < 12'h080;
    wire logic setupRd = apbReq.psel && !apbReq.penable && !apbReq.pwrite;
    wire logic accWr = apbReq.psel && apbReq.penable && apbReq.pwrite;
    wire logic [4:0] portIdx = apbReq.paddr[6:2];
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_pulse_once:
        assert property (traceOut.valid |=> !traceOut.valid) else $error("valid too long");
    a_fixed_fields:
        assert property (traceOut.valid |-> traceOut.master == 16'h0000 && traceOut.marked && traceOut.timestamped)
        else $error("bad fixed fields");
    a_write_cause:
        assert property (traceOut.valid |-> $past(accWr) && $past(stimAdr) && $past(traceReady)
            && traceOut.port == $past(portIdx) && traceOut.data == $past(apbReq.pwdata)) else $error("bad cause");
    a_drop_full:
        assert property (accWr && stimAdr && !traceReady |=> !traceOut.valid) else $error("full write sent");
    a_trig_valid:
        assert property (traceOut.trigger |-> traceOut.valid) else $error("lone trigger");
    a_idle_zero:
        assert property (!traceOut.valid |-> traceOut == '0) else $error("idle not zero");
    a_no_wait:
        assert property (apbReq.psel |-> apbRsp.pready && !apbRsp.pslverr) else $error("bad answer");
    a_ready_full:
        assert property (setupRd && stimAdr && !traceReady |=> apbRsp.prdata == 32'h0) else $error("ready when full");
    a_beyond_ports:
        assert property (accWr && apbReq.paddr == 12'h080 |=> !traceOut.valid) else $error("port 32 sent");
endmodule

bind stimulus_port_enable_trigger stim_gate_properties chk_u (.clock(clock), .reset(reset), .apbReq(apbReq),
    .apbRsp(apbRsp), .traceReady(traceReady), .traceOut(traceOut));

// *** tb/stimulus_port_enable_trigger_bench.sv ***
`timescale 1ns/1ps
`include "stim_gate_regs.svh"
module stimulus_port_enable_trigger_bench;
    logic clock;
    logic reset;
    logic stall;
    logic traceReady;
    logic [7:0] rxCount;
    logic [31:0] rd;
    stim_gate_pkg::apb_req_t apbReq;
    stim_gate_pkg::apb_rsp_t apbRsp;
    stim_gate_pkg::trace_write_t traceOut;
    stim_gate_pkg::trace_write_t rxLast;
    int err_count = 0;
    int checks = 0;
    stimulus_port_enable_trigger dut_u (.clock(clock), .reset(reset), .apbReq(apbReq), .apbRsp(apbRsp),
        .traceReady(traceReady), .traceOut(traceOut));
    trace_sink_model sink_u (.clock(clock), .reset(reset), .traceOut(traceOut), .traceReady(traceReady),
        .stall(stall), .rxCount(rxCount), .rxLast(rxLast));
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task summarize;
        if (err_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s exp %h got %h", name, exp, got);
        end
    endtask
    // ------------------------------------------------------------
    // APB master
    // ------------------------------------------------------------
    task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        apbReq.paddr <= a;
        apbReq.psel <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite <= w;
        apbReq.pwdata <= d;
        @(posedge clock);
        apbReq.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (apbRsp.pready !== 1'b1 && n < 16);
        if (apbRsp.pready !== 1'b1)
        begin
            err_count++;
            summarize();
        end
        rd = apbRsp.prdata;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        @(posedge clock);
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] exp, input string name);
        xfer(a, 1'b0, 32'h0);
        chk(name, exp, rd);
    endtask
    // Stimulus write, then the sink log tells whether it went out
    task stim(input logic [4:0] p, input logic [31:0] d, input logic en, input logic trg);
        logic [7:0] c;
        c = rxCount;
        xfer({5'h00, p, 2'h0}, 1'b1, d);
        @(posedge clock);
        chk("count", {24'h0, c + {7'h0, en}}, {24'h0, rxCount});
        if (en)
        begin
            chk("port", {27'h0, p}, {27'h0, rxLast.port});
            chk("data", d, rxLast.data);
            chk("trig", {31'h0, trg}, {31'h0, rxLast.trigger});
        end
    endtask
    initial
    begin
        reset = 1'b1;
        stall = 1'b0;
        apbReq = '0;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        rdchk(`PORT_EN_OFS, 32'h0, "en_rst");
        rdchk(`TRIG_EN_OFS, 32'h0, "trg_rst");
        rdchk(`FEAT2_OFS, 32'h3, "feat2");
        rdchk(12'h014, 32'h0, "rdy_off");
        xfer(`PORT_EN_OFS, 1'b1, 32'h8000_0005);
        xfer(`TRIG_EN_OFS, 1'b1, 32'h8000_0001);
        rdchk(`PORT_EN_OFS, 32'h8000_0005, "en_rb");
        rdchk(`TRIG_EN_OFS, 32'h8000_0001, "trg_rb");
        rdchk(12'h000, 32'h1, "rdy0");
        rdchk(12'h07c, 32'h1, "rdy31");
        stim(5'd0, 32'hcafe_0001, 1'b1, 1'b1);
        stim(5'd31, 32'h1234_5678, 1'b1, 1'b1);
        stim(5'd2, 32'h0000_00a5, 1'b1, 1'b0);
        stim(5'd1, 32'hdead_beef, 1'b0, 1'b0);
        stall <= 1'b1;
        rdchk(12'h000, 32'h0, "rdy_full");
        stim(5'd0, 32'h5555_aaaa, 1'b0, 1'b0);
        stall <= 1'b0;
        xfer(`PORT_SEL_OFS, 1'b1, 32'h0010_0003);
        rdchk(12'h000, 32'h0, "rdy_grp");
        xfer(`PORT_SEL_OFS, 1'b1, 32'h0010_0001);
        stim(5'd0, 32'h0000_0011, 1'b1, 1'b0);
        xfer(`PORT_SEL_OFS, 1'b1, 32'h0050_0002);
        rdchk(`PORT_SEL_OFS, 32'h0050_0001, "mode_rsvd");
        xfer(`PORT_SEL_OFS, 1'b1, 32'h0050_0000);
        stim(5'd0, 32'h0000_0022, 1'b1, 1'b1);
        xfer(12'h080, 1'b1, 32'hffff_ffff);
        rdchk(12'h080, 32'h0, "no_port32");
        reset <= 1'b1;
        @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        rdchk(`PORT_EN_OFS, 32'h0, "en_rst2");
        summarize();
    end
endmodule

// *** tb/trace_sink_model.sv ***
`timescale 1ns/1ps
module trace_sink_model
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Trace side
    input stim_gate_pkg::trace_write_t traceOut,
    output logic traceReady,
    // Bench control and log
    input wire logic stall,
    output logic [7:0] rxCount,
    output stim_gate_pkg::trace_write_t rxLast
);
    // Slow answer: readiness withheld while stalled
    assign traceReady = !stall;
    always @(posedge clock)
    begin
        if (reset)
            rxCount <= 8'h00;
        else if (traceOut.valid)
        begin
            rxCount <= rxCount + 8'h01;
            rxLast <= traceOut;
        end
    end
endmodule
